/* hw/ubf_bulk_in_transmitter.sv */
// Bulk-in transmitter: packs received frames into USB bulk-in packets.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ubf_bulk_in_transmitter
    import ubf_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [7:0] rxf_frames_i,
    input wire logic [31:0] rxf_data_i,
    output logic rxf_pop_o,
    output logic rxf_advance_o,
    output logic rxf_rewind_o,
    input wire logic in_token_i,
    output ubf_answer_t answer_o,
    output logic [10:0] pkt_len_o,
    output logic [5:0] pkt_count_o,
    input wire logic tx_rd_i,
    output logic [31:0] tx_data_o,
    input wire logic in_ack_i,
    input wire logic in_fail_i
);

    function automatic logic [PTR_W-1:0] words_of(input logic [14:0] bytes);
        words_of = PTR_W'((bytes + 15'h0003) >> 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    ubf_cfg_t cfg;
    logic [7:0] bcap;
    logic [15:0] dly;
    ubf_state_t state, next_state;
    logic [31:0] mem [0:DATA_WORDS-1];
    logic [PTR_W-1:0] wr_ptr, rel_ptr, rd_ptr;
    logic [LEN_W-1:0] cmd_mem [0:CMD_DEPTH-1];
    logic [CMD_AW-1:0] cmd_wp, cmd_rp;
    logic [CNT_W-1:0] cmd_cnt;
    logic [14:0] rem, next_rem;
    logic [10:0] pkt_len, next_pkt_len;
    logic [16:0] burst_cur, next_burst_cur;
    logic in_burst, inflight, from_q;
    logic [4:0] us_div;
    logic [15:0] wait_us;

    logic [10:0] mps, pkt_aligned, head_len, push_len;
    logic [PTR_W:0] free_words;
    logic [14:0] frame_bytes;
    logic [2:0] word_bytes;
    logic [18:0] burst_max, burst_sum;
    logic frame_avail, rx_empty, fits_space, cmd_full, burst_over, may_start;
    logic start, write_word, frame_last, pkt_full, push, pop_cmd;
    logic delay_on, timer_done, us_tick, idle_empty;
    logic [31:0] rd_mux;

    assign mps = cfg.high_speed ? MPS_HS : MPS_FS;
    assign free_words = (PTR_W+1)'(DATA_WORDS) - {1'b0, wr_ptr - rel_ptr};
    assign frame_bytes = {1'b0, rxf_data_i[FLEN_LSB +: FLEN_W]} + HDR_BYTES;
    assign fits_space = {1'b0, words_of(frame_bytes)} <= free_words;
    assign frame_avail = (rxf_frames_i != 8'h00) && !rxf_pop_o;
    assign rx_empty = rxf_frames_i == 8'h00;
    assign cmd_full = cmd_cnt == CNT_W'(CMD_DEPTH);
    assign burst_max = {11'h000, bcap} * {8'h00, mps};
    assign burst_sum = {2'b00, burst_cur} + {4'h0, frame_bytes};
    // overflow ends burst
    // Only a waiting frame can overflow; a drained head holds no length.
    assign burst_over = cfg.burst_limit_enable && in_burst && frame_avail &&
                        (burst_sum > burst_max);
    assign may_start = frame_avail && fits_space && !cmd_full && !burst_over
                       && (cfg.multi_frame_packing || !in_burst);
    assign start = (state == ST_IDLE || state == ST_WAIT) && may_start;
    // pad only before a following frame
    assign pkt_aligned = (pkt_len + 11'h003) & 11'h7FC;
    assign pkt_full = pkt_len == mps;
    assign write_word = (state == ST_COPY) && !pkt_full && !rxf_pop_o &&
                        !cmd_full;
    assign word_bytes = (rem > 15'h0004) ? 3'h4 : rem[2:0];
    assign frame_last = rem <= 15'h0004;
    assign push = ((state == ST_TERM) || (state == ST_COPY && pkt_full)) &&
                  !cmd_full;
    assign push_len = pkt_full ? mps : pkt_len;
    assign pop_cmd = in_ack_i && inflight && from_q;
    assign head_len = cmd_mem[cmd_rp];
    assign delay_on = cfg.multi_frame_packing && (dly != 16'h0000);
    assign timer_done = wait_us >= dly;
    assign us_tick = us_div == US_DIV_LAST;
    assign idle_empty = (state == ST_IDLE) && !in_burst && rx_empty;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_COPY;
                end else if (in_burst && !rxf_pop_o &&
                             (!frame_avail || burst_over)) begin
                    next_state = (delay_on && !burst_over) ? ST_WAIT : ST_TERM;
                end
            end
            ST_COPY: begin
                if (write_word && frame_last) begin
                    next_state = cfg.multi_frame_packing ? ST_IDLE : ST_TERM;
                end
            end
            ST_WAIT: begin
                if (start) begin
                    next_state = ST_COPY;
                end else if (timer_done || burst_over) begin
                    next_state = ST_TERM;
                end
            end
            ST_TERM: begin
                if (push && !pkt_full) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_comb begin
        next_pkt_len = pkt_len;
        next_rem = rem;
        next_burst_cur = burst_cur;
        if (start) begin
            next_pkt_len = pkt_aligned;
            next_rem = frame_bytes;
        end else if (write_word) begin
            next_pkt_len = pkt_len + 11'(word_bytes);
            next_rem = rem - 15'(word_bytes);
            next_burst_cur = burst_cur + 17'(word_bytes);
        end else if (push) begin
            next_pkt_len = 11'h000;
            if (state == ST_TERM && !pkt_full) begin
                next_burst_cur = 17'h00000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            pkt_len <= 11'h000;
            rem <= 15'h0000;
            burst_cur <= 17'h00000;
            in_burst <= 1'b0;
            rxf_pop_o <= 1'b0;
        end else begin
            state <= next_state;
            pkt_len <= next_pkt_len;
            rem <= next_rem;
            burst_cur <= next_burst_cur;
            rxf_pop_o <= write_word;
            if (start) begin
                in_burst <= 1'b1;
            end else if (push && state == ST_TERM && !pkt_full) begin
                in_burst <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (write_word) begin
            mem[wr_ptr[PTR_W-2:0]] <= rxf_data_i;
        end
        if (tx_rd_i) begin
            tx_data_o <= mem[rd_ptr[PTR_W-2:0]];
        end
    end

    // every packet on a fresh word
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rel_ptr <= '0;
        end else begin
            if (write_word) begin
                wr_ptr <= wr_ptr + 12'h001;
            end
            if (pop_cmd) begin
                rel_ptr <= rel_ptr + words_of({4'h0, head_len});
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            cmd_mem[cmd_wp] <= push_len;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_wp <= '0;
            cmd_rp <= '0;
            cmd_cnt <= '0;
            pkt_len_o <= 11'h000;
            pkt_count_o <= 6'h00;
        end else begin
            cmd_wp <= cmd_wp + CMD_AW'(push);
            cmd_rp <= cmd_rp + CMD_AW'(pop_cmd);
            cmd_cnt <= cmd_cnt + CNT_W'(push) - CNT_W'(pop_cmd);
            pkt_len_o <= (cmd_cnt != 6'h00) ? head_len : 11'h000;
            pkt_count_o <= cmd_cnt;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            us_div <= 5'h00;
            wait_us <= 16'h0000;
        end else if (state != ST_WAIT) begin
            us_div <= 5'h00;
            wait_us <= 16'h0000;
        end else begin
            us_div <= us_tick ? 5'h00 : us_div + 5'h01;
            wait_us <= wait_us + 16'(us_tick);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tokens are answered the cycle after they arrive; a token that lands
    // while a packet awaits its handshake is refused to keep one in flight.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            answer_o <= '0;
            inflight <= 1'b0;
            from_q <= 1'b0;
            rd_ptr <= '0;
            rxf_advance_o <= 1'b0;
            rxf_rewind_o <= 1'b0;
        end else begin
            answer_o <= '0;
            rxf_advance_o <= pop_cmd;
            rxf_rewind_o <= in_fail_i && inflight && from_q;
            if (in_ack_i || in_fail_i) begin
                inflight <= 1'b0;
            end
            if (tx_rd_i) begin
                rd_ptr <= rd_ptr + 12'h001;
            end
            if (in_token_i && !inflight) begin
                rd_ptr <= rel_ptr;
                if (cmd_cnt != 6'h00) begin
                    answer_o <= '{send: 1'b1, nak: 1'b0, len: head_len};
                    inflight <= 1'b1;
                    from_q <= 1'b1;
                end else if (idle_empty && cfg.empty_in_response) begin
                    answer_o <= '{send: 1'b1, nak: 1'b0, len: 11'h000};
                    inflight <= 1'b1;
                    from_q <= 1'b0;
                end else begin
                    answer_o <= '{send: 1'b0, nak: 1'b1, len: 11'h000};
                end
            end else if (in_token_i) begin
                answer_o <= '{send: 1'b0, nak: 1'b1, len: 11'h000};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rd_mux = (reg_addr_i == REG_CFG) ? {28'h0000000, cfg} :
                    (reg_addr_i == REG_BCAP) ? {24'h000000, bcap} :
                    (reg_addr_i == REG_DLY) ? {16'h0000, dly} :
                    (reg_addr_i == REG_STAT) ?
                        {23'h000000, state == ST_WAIT, in_burst, cmd_full,
                         cmd_cnt} :
                    32'h00000000;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg <= CFG_RST;
            bcap <= BCAP_RST;
            dly <= DLY_RST;
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
            if (reg_wr_i && reg_addr_i == REG_CFG) begin
                cfg <= reg_wdata_i[3:0];
            end
            if (reg_wr_i && reg_addr_i == REG_BCAP) begin
                bcap <= reg_wdata_i[7:0];
            end
            if (reg_wr_i && reg_addr_i == REG_DLY) begin
                dly <= reg_wdata_i[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_fail_q;
        in_fail_i && inflight && from_q;
    endsequence
    sequence s_rewound;
        rxf_rewind_o && !rxf_advance_o;
    endsequence

    a_queue_depth_bound: assert property (
        cmd_cnt <= 6'h20) else $error("length queue above 32 entries");
    a_full_stalls_data: assert property (
        cmd_full && !in_ack_i |=> $stable(wr_ptr) && cmd_cnt == 6'h20)
        else $error("data moved while length queue full");
    a_count_follows_queue: assert property (
        cmd_full |=> pkt_count_o == 6'h20)
        else $error("packet count does not follow queue");
    a_nak_when_empty: assert property (
        in_token_i && !inflight && cmd_cnt == 6'h00 &&
        !cfg.empty_in_response |=> answer_o.nak && !answer_o.send)
        else $error("token not refused with nothing queued");
    a_zlp_when_empty: assert property (
        in_token_i && !inflight && cmd_cnt == 6'h00 && idle_empty &&
        cfg.empty_in_response |=> answer_o.send && answer_o.len == 11'h000)
        else $error("empty response not a zero-length packet");
    a_push_len_max: assert property (
        push |-> push_len <= mps) else $error("packet longer than maximum");
    a_single_frame_end: assert property (
        write_word && frame_last && !cfg.multi_frame_packing
        |=> state == ST_TERM) else $error("single frame not terminated");
    a_start_aligned: assert property (
        start |=> pkt_len[1:0] == 2'b00) else $error("frame not word aligned");
    a_rewind_keeps: assert property (
        s_fail_q |=> s_rewound ##0 cmd_cnt >= $past(cmd_cnt))
        else $error("failed packet not kept for retry");
    a_defer_enters: assert property (
        state == ST_IDLE && in_burst && !rxf_pop_o && !frame_avail &&
        delay_on |=> state == ST_WAIT)
        else $error("terminator not deferred");
    a_ack_advances: assert property (
        in_ack_i && inflight && from_q |=> rxf_advance_o ##1 !rxf_advance_o)
        else $error("acknowledge did not advance upstream");

endmodule // ubf_bulk_in_transmitter
`default_nettype wire

/* hw/ubf_pkg.sv */
// Constants and types for the bulk-in frame encapsulator.
//
// Behaviour
// - Packet data sits in a dual-port RAM of 2K words by 32 bits.
// - Packets and frames start on 32-bit word boundaries.
// - Inner pad bytes count in packet length; trailing pad bytes never do.
// - Every finished packet, zero-length too, pushes its length to the queue.
// - Length queue holds 32 entries and shows full.
// - Queue head is the packet length, occupancy the packet count.
// - A config bit picks multi-frame or single-frame packing.
// - Single-frame packing carries one frame per transfer, split if long.
// - Frame length comes from the first of three header words.
// - In multi-frame packing pad only when another frame follows.
// - Pad bytes are not part of the header length.
// - Burst ends short, or with a ZLP on an exact multiple.
// - Move a frame only when complete upstream and buffer space exists.
// - Single-frame packing sends a ZLP after a frame of whole packets.
// - Single-frame packing never pads; transfer ends on the last byte.
// - Token with nothing to send: ZLP if empty response set, else NAK.
// - A burst limit caps one transfer at every speed.
// - Multi-frame packing defers the terminator by a delay; zero disables.
// - The delay timer starts after the last full packet; expiry flushes.
// - New data making a full packet goes out and restarts the delay.
// - A lone short frame into an empty buffer also starts the timer.
// - Tokens are NAKed while waiting for data or the delay.
// - Limit counts in packet units, only when enabled, skips first frame.
// - Enforced limit ends burst on no data or on overflow by next frame.
// - An unacknowledged packet is resent; advance only after acknowledge.
package ubf_pkg;

    localparam int DATA_WORDS = 2048;
    localparam int PTR_W = 12;
    localparam int CMD_DEPTH = 32;
    localparam int CMD_AW = 5;
    localparam int CNT_W = 6;
    localparam int LEN_W = 11;
    localparam int FLEN_LSB = 0;
    localparam int FLEN_W = 14;
    localparam logic [14:0] HDR_BYTES = 15'h000C;
    localparam logic [10:0] MPS_HS = 11'h200;
    localparam logic [10:0] MPS_FS = 11'h040;

    localparam int CLK_HZ = 25_000_000;
    localparam int DELAY_UNIT_HZ = 1_000_000;
    localparam int US_CYCLES = CLK_HZ / DELAY_UNIT_HZ;
    localparam logic [4:0] US_DIV_LAST = 5'(US_CYCLES - 1);
    localparam int DELAY_DEF_US = 34;

    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_BCAP = 4'h4;
    localparam logic [3:0] REG_DLY = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    localparam logic [3:0] CFG_RST = 4'h9;
    localparam logic [7:0] BCAP_RST = 8'h00;
    localparam logic [15:0] DLY_RST = 16'(DELAY_DEF_US);
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_FULL_BIT = 6;
    localparam int STAT_BURST_BIT = 7;
    localparam int STAT_WAIT_BIT = 8;

    typedef struct packed {
        logic high_speed;
        logic burst_limit_enable;
        logic empty_in_response;
        logic multi_frame_packing;
    } ubf_cfg_t;

    typedef struct packed {
        logic send;
        logic nak;
        logic [10:0] len;
    } ubf_answer_t;

    typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_WAIT, ST_TERM} ubf_state_t;

endpackage

/* sim/ubf_rxf_model.sv */
// Behavioural upstream FIFO controller that hands over complete frames.
`timescale 1ns/100ps
`default_nettype none
module ubf_rxf_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic pop_i,
    input wire logic advance_i,
    input wire logic rewind_i,
    output logic [7:0] frames_o,
    output logic [31:0] data_o
);
    logic [31:0] mem [0:4095];
    int fend [0:63];
    int wr = 0;
    int rd = 0;
    int nf = 0;
    int done = 0;
    int n_adv = 0;
    int n_rew = 0;
    logic [31:0] last = 32'h0;

    //////////////////////////////////////////////////////////////////////
    // complete frames only.
    assign frames_o = 8'(nf - done);
    // A drained head shows the inverse of the last word, so stale reads show.
    assign data_o = (rd < wr) ? mem[rd] : ~last;

    task automatic push_word(input logic [31:0] w, input logic eof);
        mem[wr] = w;
        wr = wr + 1;
        if (eof) begin
            fend[nf] = wr;
            nf = nf + 1;
        end
    endtask

    // The counts of advance and rewind pulses are kept only as statistics.
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd <= 0;
            done <= 0;
        end else begin
            if (pop_i && rd < wr) begin
                last <= mem[rd];
                rd <= rd + 1;
                if (rd + 1 == fend[done]) begin
                    done <= done + 1;
                end
            end
            n_adv <= n_adv + int'(advance_i);
            n_rew <= n_rew + int'(rewind_i);
        end
    end
endmodule // ubf_rxf_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking testbench for the bulk-in frame encapsulator.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ubf_pkg::*;
;
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [31:0] data;
    } ubf_row_t;

    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [7:0] rxf_frames_i;
    logic [31:0] rxf_data_i;
    logic rxf_pop_o;
    logic rxf_advance_o;
    logic rxf_rewind_o;
    logic in_token_i = 1'b0;
    ubf_answer_t answer_o;
    logic [10:0] pkt_len_o;
    logic [5:0] pkt_count_o;
    logic tx_rd_i = 1'b0;
    logic [31:0] tx_data_o;
    logic in_ack_i = 1'b0;
    logic in_fail_i = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    int base = 0;
    int k;
    logic [31:0] d;
    logic [31:0] exp_w [$];
    ubf_row_t rows [0:9] = '{
        '{1'b0, REG_CFG, 32'h9}, '{1'b0, REG_BCAP, 32'h0},
        '{1'b0, REG_DLY, 32'h22}, '{1'b0, REG_STAT, 32'h0},
        '{1'b1, REG_BCAP, 32'h1FF}, '{1'b0, REG_BCAP, 32'hFF},
        '{1'b1, REG_DLY, 32'h2}, '{1'b0, REG_DLY, 32'h2},
        '{1'b1, 4'h6, 32'h5}, '{1'b0, 4'h6, 32'h0}};

    always #20 clk_i = ~clk_i;

    ubf_bulk_in_transmitter DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .rxf_frames_i(rxf_frames_i), .rxf_data_i(rxf_data_i),
        .rxf_pop_o(rxf_pop_o), .rxf_advance_o(rxf_advance_o),
        .rxf_rewind_o(rxf_rewind_o), .in_token_i(in_token_i),
        .answer_o(answer_o), .pkt_len_o(pkt_len_o),
        .pkt_count_o(pkt_count_o), .tx_rd_i(tx_rd_i),
        .tx_data_o(tx_data_o), .in_ack_i(in_ack_i), .in_fail_i(in_fail_i));

    ubf_rxf_model RXF (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .pop_i(rxf_pop_o), .advance_i(rxf_advance_o),
        .rewind_i(rxf_rewind_o), .frames_o(rxf_frames_i),
        .data_o(rxf_data_i));

    //////////////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] e,
                            input string m);
        n_tests++;
        if (got !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, e);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic e, input string m);
        n_tests++;
        if (got !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // A refusal carries a zero length, yet only a send has its length checked.
    task automatic cmp_ans(input ubf_answer_t got, input logic [10:0] len,
                           input logic snd);
        n_tests++;
        if ({got.send, got.nak} !== {snd, !snd} || (snd && got.len !== len))
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: token answer %h", $time, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask

    // Bits of sel: fail, ack, word read, token.
    task automatic usb_pulse(input logic [3:0] sel);
        @(posedge clk_i);
        {in_fail_i, in_ack_i, tx_rd_i, in_token_i} <= sel;
        @(posedge clk_i);
        {in_fail_i, in_ack_i, tx_rd_i, in_token_i} <= 4'h0;
        #1;
    endtask

    task automatic push_frame(input int len, input logic [7:0] tag);
        int n;
        logic [31:0] w;
        n = 3 + (len + 3) / 4;
        for (int i = 0; i < n; i++) begin
            w = (i == 0) ? 32'(len) : {tag, 8'h5A, 16'(i)};
            exp_w.push_back(w);
            RXF.push_word(w, i == n - 1);
        end
    endtask

    task automatic serve(input logic [10:0] len, input logic ack);
        for (k = 0; k < 3000 && pkt_count_o === 6'h00; k++) begin
            @(posedge clk_i);
            #1;
        end
        cmp_word(32'(pkt_len_o), 32'(len), "queue head");
        usb_pulse(4'h1);
        cmp_ans(answer_o, len, 1'b1);
        for (int i = 0; i < (32'(len) + 3) / 4; i++) begin
            usb_pulse(4'h2);
            cmp_word(tx_data_o, exp_w[base + i], "packet word");
        end
        usb_pulse(ack ? 4'h4 : 4'h8);
        cmp_bit(ack ? rxf_advance_o : rxf_rewind_o, 1'b1, "ack result");
        if (ack) begin
            base += (32'(len) + 3) / 4;
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////
    // The whole run needs under two thousand cycles; twenty thousand is ample.
    initial begin
        #800_000;
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                reg_wr(rows[i].addr, rows[i].data);
            end else begin
                reg_rd(rows[i].addr, d);
                cmp_word(d, rows[i].data, "register");
            end
        end
        usb_pulse(4'h1);
        cmp_ans(answer_o, 11'h000, 1'b0);
        reg_wr(REG_CFG, 32'h8);
        push_frame(100, 8'hA1);
        serve(11'd112, 1'b0);
        serve(11'd112, 1'b1);
        push_frame(500, 8'hA2);
        serve(11'd512, 1'b1);
        serve(11'd0, 1'b1);
        reg_wr(REG_CFG, 32'h9);
        push_frame(1, 8'hB1);
        push_frame(1, 8'hB2);
        d = 32'h0;
        for (k = 0; k < 200 && d[STAT_WAIT_BIT] !== 1'b1; k++) begin
            reg_rd(REG_STAT, d);
        end
        usb_pulse(4'h1);
        cmp_ans(answer_o, 11'h000, 1'b0);
        for (k = 0; k < 200 && pkt_count_o === 6'h00; k++) begin
            @(posedge clk_i);
            #1;
        end
        cmp_bit(k >= 35 && k <= 60, 1'b1, "delay span");
        serve(11'd29, 1'b1);
        reg_wr(REG_BCAP, 32'h1);
        reg_wr(REG_CFG, 32'hD);
        for (int i = 0; i < 3; i++) begin
            push_frame(188, 8'hC0 + 8'(i));
        end
        serve(11'd400, 1'b1);
        serve(11'd200, 1'b1);
        reg_wr(REG_CFG, 32'hB);
        usb_pulse(4'h1);
        cmp_ans(answer_o, 11'h000, 1'b1);
        cmp_word(32'(pkt_count_o), 32'h0, "queue drained");
        cmp_word(32'(RXF.n_adv), 32'h6, "advance count");
        cmp_word(32'(RXF.n_rew), 32'h1, "rewind count");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
